// ### verilog/oag_pkg.sv
package oag_pkg;

   // ------------------------------------------------------------
   // address map constants
   // ------------------------------------------------------------
   localparam logic [15:0] SHORT_LO = 16'hfe20;   // first short address
   localparam logic [15:0] SHORT_HI = 16'hff1f;   // last short address
   localparam logic [15:0] RAM_HI = 16'hfeff;     // end of fast ram
   localparam logic [15:0] SFR_BASE = 16'hff00;   // special register page
   localparam logic [15:0] SFR_TOP = 16'hffff;    // end of register page
   localparam logic [7:0] SHORT_WRAP = 8'h20;     // field below this -> ff page
   localparam logic [6:0] SHORT_UPPER = 7'h7f;    // bits 15..9 of short ea
   localparam int SHORT_BIT8 = 8;                 // flipped page bit
   localparam logic [7:0] OP_PUSH_SECOND = 8'haa; // push second pointer pair
   localparam logic [15:0] ADDR_RST = 16'h0000;   // address after reset

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_DIRECT,
      MODE_SHORT,
      MODE_SHORT_PAIR,
      MODE_SFR,
      MODE_INDIRECT,
      MODE_BASED,
      MODE_STACK,
      MODE_REG
   } mode_t;

   typedef enum logic [1:0] {
      TGT_NONE,
      TGT_RAM,
      TGT_SFR,
      TGT_OTHER
   } target_t;

   typedef struct packed {
      logic valid;          // request strobe
      mode_t mode;          // addressing mode
      logic [7:0] opcode;   // raw opcode
      logic [7:0] field8;   // short/sfr/offset field
      logic [15:0] abs16;   // absolute_operand
      logic [2:0] reg_sel;  // byte register code
      logic [1:0] pair_sel; // register_pair_operand code
      logic ptr_sel;        // 0 second_pointer_pair, 1 base_pointer_pair
      logic stack_op;       // push/pop/call/ret/interrupt save
   } req_t;

   typedef struct packed {
      logic valid;          // result strobe
      logic [15:0] addr;    // effective address
      target_t target;      // region selected
      logic is_reg;         // operand is a register
      logic is_pair;        // register operand is a pair
      logic [2:0] reg_num;  // register number 0..7 or pair 0..3
      logic fault;          // odd pair address or stack off ram
      logic push_second;    // opcode pushes second pointer pair
   } res_t;

   typedef struct packed {
      logic [15:0] second_pair; // second_pointer_pair value
      logic [15:0] base_pair;   // base_pointer_pair value
      logic [15:0] stack_ptr;   // stack_pointer value
   } ptrs_t;

endpackage

// ### verilog/oag_region.sv
`timescale 1ns/1ps
module oag_region (
   input wire logic clk_i,                  // core clock
   input wire logic nrst_i,                 // async reset, low
   input wire logic [15:0] addr_i,          // address to classify
   output oag_pkg::target_t target_o,       // registered region
   output logic in_ram_o                    // registered ram flag
);
   import oag_pkg::*;

   // ------------------------------------------------------------
   // region classify
   // ------------------------------------------------------------
   typedef struct packed {
      target_t target;
      logic in_ram;
   } reg_state_t;

   reg_state_t state;
   reg_state_t next_state;

   // fast ram is fe20..feff, register page is ff00..ffff
   always_comb begin
      next_state = state;
      next_state.in_ram = (addr_i >= SHORT_LO) && (addr_i <= RAM_HI);
      if (next_state.in_ram) begin
         next_state.target = TGT_RAM;
      end else if (addr_i >= SFR_BASE) begin
         next_state.target = TGT_SFR;
      end else begin
         next_state.target = TGT_OTHER;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= '{target: TGT_NONE, in_ram: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign target_o = state.target;
   assign in_ram_o = state.in_ram;
endmodule

// ### verilog/operand_address_generator.sv
// Functional notes
// - Short direct operands reach only the 256 bytes fe20 to ff1f.
// - Short ea bit 8 is 0 for field 20..ff and 1 for field 00..1f.
// - Short fe20..feff selects fast ram, ff00..ff1f special registers.
// - The pair-sized short operand accepts only even addresses.
// - Special register mode maps the 8-bit field onto ff00 to ffff.
// - Registers at ff00..ff1f are reached by both short mode and sfr mode.
// - Byte register operands pick one of eight by a 3-bit code.
// - Operands name byte registers 0..7 and pairs 0..3.
// - Indirect mode uses one of two pointer pairs as a full address.
// - Based mode adds a zero-extended offset to the base pair mod 2^16.
// - Stack addressing applies to push, pop, call, return, irq save.
// - Stack accesses target only the fast ram area.
// - Opcode aa is recognised as pushing the second pointer pair.
// - Direct mode uses the 16-bit immediate unmodified.
`timescale 1ns/1ps
module operand_address_generator (
   input wire logic clk_i,                   // core clock, 100 MHz
   input wire logic nrst_i,                  // async reset, low
   input oag_pkg::req_t req_i,               // decoder request
   input oag_pkg::ptrs_t ptrs_i,             // pointer pair values
   output oag_pkg::res_t res_o               // registered result
);
   import oag_pkg::*;

   // every check below runs on the core clock and rests during reset
   default clocking chk_clk @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      res_t res;
      logic need_ram;   // result must lie in fast ram
   } state_t;

   state_t state;
   state_t next_state;
   logic [15:0] ea;
   logic [15:0] short_ea;
   logic [16:0] based_sum;
   target_t region;
   logic region_ram;

   // short ea: upper page bits forced, bit 8 inverted from window
   always_comb begin
      short_ea = {SHORT_UPPER, (req_i.field8 < SHORT_WRAP),
                  req_i.field8};
      based_sum = {1'b0, ptrs_i.base_pair} + {9'h000, req_i.field8};
   end

   // ------------------------------------------------------------
   // effective address mux
   // ------------------------------------------------------------
   always_comb begin
      ea = ADDR_RST;
      case (req_i.mode)
         MODE_DIRECT: ea = req_i.abs16;
         MODE_SHORT: ea = short_ea;
         MODE_SHORT_PAIR: ea = short_ea;
         MODE_SFR: ea = {SFR_BASE[15:8], req_i.field8};
         MODE_INDIRECT: begin
            // full space, pointer pair chosen by one select bit
            ea = req_i.ptr_sel ? ptrs_i.base_pair
                               : ptrs_i.second_pair;
         end
         MODE_BASED: ea = based_sum[15:0]; // carry dropped
         MODE_STACK: ea = ptrs_i.stack_ptr;
         default: ea = ADDR_RST;
      endcase
      // stack instructions use the stack pointer whatever mode is coded
      if (req_i.stack_op) begin
         ea = ptrs_i.stack_ptr;
      end
   end

   // ------------------------------------------------------------
   // result register
   // ------------------------------------------------------------
   // region tag is registered in the leaf, so it lines up with res
   oag_region u_region (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .addr_i(ea),
      .target_o(region),
      .in_ram_o(region_ram)
   );

   always_comb begin
      next_state = state;
      next_state.res.valid = req_i.valid;
      next_state.res.addr = ea;
      next_state.res.is_reg = (req_i.mode == MODE_REG);
      next_state.res.is_pair = 1'b0;
      next_state.res.reg_num = req_i.reg_sel;
      next_state.res.fault = 1'b0;
      next_state.res.push_second = req_i.valid &&
                                   (req_i.opcode == OP_PUSH_SECOND);
      next_state.need_ram = req_i.valid &&
                            (req_i.mode == MODE_STACK || req_i.stack_op);
      if (req_i.mode == MODE_REG && req_i.stack_op == 1'b0 &&
          req_i.pair_sel != 2'b00 && req_i.reg_sel == 3'b000) begin
         // reg_sel 0 with a nonzero pair code still leaves is_pair clear; ptr_sel picks pairs
         next_state.res.is_pair = 1'b0;
      end
      if (req_i.mode == MODE_REG) begin
         next_state.res.addr = ADDR_RST;
      end
      if (req_i.mode == MODE_SHORT_PAIR) begin
         next_state.res.fault = req_i.valid & short_ea[0];
      end
      // any stack access, by mode or by instruction, must stay in ram
      if (next_state.need_ram) begin
         next_state.res.fault = !((ea >= SHORT_LO) &&
                                  (ea <= RAM_HI));
      end
      if (req_i.mode == MODE_REG && req_i.ptr_sel) begin
         // ptr_sel on a register request picks the pair view
         next_state.res.is_pair = 1'b1;
         next_state.res.reg_num = {1'b0, req_i.pair_sel};
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // registers at ff00..ff1f come from short or sfr mode: both map there
   always_comb begin
      res_o = state.res;
      res_o.target = state.res.is_reg ? TGT_NONE : region;
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // ------------------------------------------------------------
   // short direct checks
   // ------------------------------------------------------------

   // short operands never leave the fe20..ff1f window
   chk_short_window: assert property (
      req_i.valid && req_i.mode == MODE_SHORT
      |=> res_o.addr >= SHORT_LO && res_o.addr <= SHORT_HI)
      else $error("short ea outside window");

   // page bit follows the field: low fields land in the register page
   chk_short_bit8: assert property (
      req_i.valid && req_i.mode == MODE_SHORT
      |=> res_o.addr[8] == ($past(req_i.field8) < 8'h20))
      else $error("short ea bit 8 wrong");

   // upper page bits are forced for byte operands
   chk_short_upper: assert property (
      req_i.valid && req_i.mode == MODE_SHORT
      |=> res_o.addr[15:9] == 7'h7f)
      else $error("short ea upper bits wrong");

   // and for pair operands, which share the same window
   chk_pair_upper: assert property (
      req_i.valid && req_i.mode == MODE_SHORT_PAIR
      |=> res_o.addr[15:9] == 7'h7f)
      else $error("short pair ea upper bits wrong");

   // region tag agrees with the address that was produced
   chk_short_region: assert property (
      req_i.valid && req_i.mode == MODE_SHORT
      |=> res_o.target == (res_o.addr <= RAM_HI ? TGT_RAM : TGT_SFR))
      else $error("short region wrong");

   // the field alone decides the region, so a bad addr still trips this
   chk_short_ram: assert property (
      req_i.valid && req_i.mode == MODE_SHORT && req_i.field8 >= 8'h20
      |=> res_o.target == TGT_RAM)
      else $error("short ram field not in ram");

   // an odd pair address is always flagged
   chk_pair_even: assert property (
      req_i.valid && req_i.mode == MODE_SHORT_PAIR
      |=> res_o.fault == res_o.addr[0])
      else $error("odd pair address not flagged");

   // pair operands stay inside the short window as well
   chk_pair_window: assert property (
      req_i.valid && req_i.mode == MODE_SHORT_PAIR
      |=> res_o.addr >= SHORT_LO && res_o.addr <= SHORT_HI)
      else $error("short pair ea outside window");

   // special register mode always lands in the top page
   chk_sfr_page: assert property (
      req_i.valid && req_i.mode == MODE_SFR
      |=> res_o.addr == {8'hff, $past(req_i.field8)} && res_o.target == TGT_SFR)
      else $error("sfr ea wrong");

   // low short fields reach the first 32 registers of the page
   chk_short_sfr: assert property (
      req_i.valid && req_i.mode == MODE_SHORT && req_i.field8 < 8'h20
      |=> res_o.target == TGT_SFR && res_o.addr[15:8] == 8'hff)
      else $error("short register field not in page");

   // ------------------------------------------------------------
   // register and pointer checks
   // ------------------------------------------------------------

   // byte register view passes the 3-bit code straight on
   chk_reg_select: assert property (
      req_i.valid && req_i.mode == MODE_REG && !req_i.ptr_sel
      |=> res_o.is_reg && !res_o.is_pair
          && res_o.reg_num == $past(req_i.reg_sel))
      else $error("byte register select wrong");

   // a register operand carries no memory address or region
   chk_reg_target: assert property (
      req_i.valid && req_i.mode == MODE_REG
      |=> res_o.is_reg && res_o.target == TGT_NONE && res_o.addr == 16'h0000)
      else $error("register operand has a region");

   // pair view returns the pair number zero-extended
   chk_pair_select: assert property (
      req_i.valid && req_i.mode == MODE_REG && req_i.ptr_sel
      |=> res_o.is_pair && res_o.reg_num == {1'b0, $past(req_i.pair_sel)})
      else $error("pair select wrong");

   // indirect mode hands over the chosen pair untouched
   chk_indirect_ptr: assert property (
      req_i.valid && req_i.mode == MODE_INDIRECT
      |=> res_o.addr == ($past(req_i.ptr_sel) ? $past(ptrs_i.base_pair)
                                              : $past(ptrs_i.second_pair)))
      else $error("indirect ea wrong");

   // offset is zero-extended and the carry is lost
   chk_based_sum: assert property (
      req_i.valid && req_i.mode == MODE_BASED
      |=> res_o.addr == 16'($past(ptrs_i.base_pair) + $past(req_i.field8)))
      else $error("based ea wrong");

   // stack mode uses the stack pointer as is
   chk_stack_ptr: assert property (
      req_i.valid && req_i.mode == MODE_STACK
      |=> res_o.addr == $past(ptrs_i.stack_ptr))
      else $error("stack ea wrong");

   // a stack instruction uses the stack pointer in every mode except MODE_REG
   chk_stack_auto: assert property (
      req_i.valid && req_i.stack_op
      |=> res_o.addr == $past(ptrs_i.stack_ptr))
      else $error("stack instruction ea wrong");

   // stack mode outside fast ram raises the fault
   chk_stack_ram: assert property (
      req_i.valid && req_i.mode == MODE_STACK
      |=> res_o.fault == (res_o.target != TGT_RAM))
      else $error("stack outside ram not flagged");

   // the registered stack marker lines up with the fault it raised
   chk_stack_flag: assert property (
      state.need_ram
      |-> res_o.fault == (res_o.target != TGT_RAM))
      else $error("stack access fault mismatch");

   // the push opcode is seen whatever mode it arrives with
   chk_push_second: assert property (
      req_i.valid && req_i.opcode == 8'haa
      |=> res_o.push_second)
      else $error("push of second pair missed");

   // and no other opcode, or an idle cycle, raises it
   chk_push_only: assert property (
      !(req_i.valid && req_i.opcode == 8'haa)
      |=> !res_o.push_second)
      else $error("push of second pair raised falsely");

   // direct mode is a plain pass-through
   chk_direct_pass: assert property (
      req_i.valid && req_i.mode == MODE_DIRECT
      |=> res_o.addr == $past(req_i.abs16))
      else $error("direct ea modified");

   // ------------------------------------------------------------
   // cover points
   // ------------------------------------------------------------
   // corner cases that the checks above should have seen at least once
   cov_short_sfr: cover property (
      req_i.valid && req_i.mode == MODE_SHORT && req_i.field8 < 8'h20);
   cov_based_wrap: cover property (
      req_i.valid && req_i.mode == MODE_BASED && based_sum[16]);
   cov_stack_fault: cover property (
      req_i.valid && req_i.mode == MODE_STACK ##1 res_o.fault);
   cov_pair_odd: cover property (
      req_i.valid && req_i.mode == MODE_SHORT_PAIR && req_i.field8[0]);
   cov_reg_pair: cover property (
      req_i.valid && req_i.mode == MODE_REG && req_i.ptr_sel);
endmodule

// ### tb/oag_partner.sv
`timescale 1ns/1ps
// decoder side: launches each request and the pointer values on the
// falling edge, so the block always samples settled inputs
module oag_partner (
   input wire logic clk_i,            // core clock
   input wire logic nrst_i,           // async reset, low
   input oag_pkg::req_t cmd_i,        // request queued by the bench
   input oag_pkg::ptrs_t ptrs_i,      // pointer values queued
   output oag_pkg::req_t req_o,       // request toward the block
   output oag_pkg::ptrs_t ptrs_o      // pointer values toward the block
);
   import oag_pkg::*;

   // ---------------------------------------------------------------
   // launch register
   // ---------------------------------------------------------------
   // stack_op is derived from the mode, as a real decoder would mark it
   always @(negedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         req_o <= '0;
         ptrs_o <= '0;
      end else begin
         req_o <= cmd_i;
         req_o.stack_op <= (cmd_i.mode == MODE_STACK);
         ptrs_o <= ptrs_i;
      end
   end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
 $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
   import oag_pkg::*;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   req_t cmd = '0;
   ptrs_t pv = '0;
   req_t req;
   ptrs_t ptrs;
   res_t res;
   res_t e;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;

   // ---------------------------------------------------------------
   // clock, partner, block
   // ---------------------------------------------------------------
   always #5 clk_i = ~clk_i;
   oag_partner oag_partner_i (.clk_i(clk_i), .nrst_i(nrst_i),
      .cmd_i(cmd), .ptrs_i(pv), .req_o(req), .ptrs_o(ptrs));
   operand_address_generator operand_address_generator_i (.clk_i(clk_i),
      .nrst_i(nrst_i), .req_i(req), .ptrs_i(ptrs), .res_o(res));

   // ---------------------------------------------------------------
   // expectation worked out from the address rules
   // ---------------------------------------------------------------
   function automatic res_t exp_of(req_t r, ptrs_t p);
      res_t x;
      x = '0;
      x.valid = r.valid;
      x.push_second = r.valid && (r.opcode == 8'haa);
      case (r.mode)
         MODE_DIRECT: x.addr = r.abs16;
         MODE_SHORT, MODE_SHORT_PAIR: x.addr = {7'h7f, r.field8 < 8'h20,
            r.field8};
         MODE_SFR: x.addr = {8'hff, r.field8};
         MODE_INDIRECT: x.addr = r.ptr_sel ? p.base_pair : p.second_pair;
         MODE_BASED: x.addr = p.base_pair + {8'h00, r.field8};
         MODE_STACK: x.addr = p.stack_ptr;
         default: begin
            x.is_reg = 1'b1;
            x.is_pair = r.ptr_sel;
            x.reg_num = r.ptr_sel ? {1'b0, r.pair_sel} : r.reg_sel;
         end
      endcase
      if (x.is_reg) x.target = TGT_NONE;
      else if (x.addr >= 16'hff00) x.target = TGT_SFR;
      else if (x.addr >= 16'hfe20 && x.addr <= 16'hfeff) x.target = TGT_RAM;
      else x.target = TGT_OTHER;
      // the fault flag is only raised for a valid request
      x.fault = r.valid && ((r.mode == MODE_SHORT_PAIR && x.addr[0]) ||
         (r.mode == MODE_STACK && x.target != TGT_RAM));
      return x;
   endfunction

   // ---------------------------------------------------------------
   // one request: queued after a rising edge, launched on the falling
   // edge, result looked at just after the capturing edge; calls in a
   // row give back-to-back requests
   // ---------------------------------------------------------------
   task automatic step(req_t r, ptrs_t p);
      cmd = r;
      pv = p;
      @(negedge clk_i);
      @(posedge clk_i);
      #1;
      e = exp_of(r, p);
      `CHK(res.valid, e.valid)
      `CHK(res.addr, e.addr)
      `CHK(res.target, e.target)
      `CHK(res.fault, e.fault)
      `CHK(res.push_second, e.push_second)
      `CHK(res.is_reg, e.is_reg)
      if (e.is_reg) begin
         `CHK(res.is_pair, e.is_pair)
         `CHK(res.reg_num, e.reg_num)
      end
   endtask

   task automatic mode_fields(mode_t m, logic [7:0] f);
      req_t r;
      r = '0;
      r.valid = 1'b1;
      r.mode = m;
      r.field8 = f;
      r.abs16 = {f, ~f};
      r.opcode = f;
      step(r, '{16'hfe40, 16'hfff0, 16'hfe80});
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_short;
      logic [7:0] fl [6] = '{8'h00, 8'h1f, 8'h20, 8'h21, 8'hff, 8'h90};
      foreach (fl[i]) mode_fields(MODE_SHORT, fl[i]);
      foreach (fl[i]) mode_fields(MODE_SHORT_PAIR, fl[i]);
   endtask

   task automatic t_sfr;
      logic [7:0] fl [4] = '{8'h00, 8'h1f, 8'h20, 8'hff};
      foreach (fl[i]) mode_fields(MODE_SFR, fl[i]);
   endtask

   task automatic t_direct;
      logic [7:0] fl [4] = '{8'h01, 8'hfe, 8'hff, 8'haa};
      foreach (fl[i]) mode_fields(MODE_DIRECT, fl[i]);
      mode_fields(MODE_DIRECT, 8'hab);
   endtask

   task automatic t_reg;
      req_t r;
      r = '0;
      r.valid = 1'b1;
      r.mode = MODE_REG;
      for (int i = 0; i < 8; i++) begin
         r.reg_sel = i[2:0];
         r.pair_sel = i[1:0];
         r.ptr_sel = i[0];
         step(r, '0);
      end
   endtask

   task automatic t_pointer;
      req_t r;
      r = '0;
      r.valid = 1'b1;
      r.mode = MODE_INDIRECT;
      step(r, '{16'h1234, 16'hfe55, 16'h0});
      r.ptr_sel = 1'b1;
      step(r, '{16'h1234, 16'hfe55, 16'h0});
      r.mode = MODE_BASED;
      r.field8 = 8'h20;
      step(r, '{16'h0, 16'hfff0, 16'h0});
      r.field8 = 8'hff;
      step(r, '{16'h0, 16'h1234, 16'h0});
      step(r, '{16'h0, 16'hff01, 16'h0});
      r.mode = MODE_STACK;
      r.opcode = 8'haa;
      step(r, '{16'h0, 16'h0, 16'hfe20});
      step(r, '{16'h0, 16'h0, 16'hfeff});
      step(r, '{16'h0, 16'h0, 16'hfe1f});
      step(r, '{16'h0, 16'h0, 16'hff00});
      r.valid = 1'b0;
      step(r, '{16'h0, 16'h0, 16'h8000});
   endtask

   // a reset in mid-run must clear the result at once
   task automatic t_reset;
      mode_fields(MODE_SHORT, 8'h10);
      @(negedge clk_i);
      nrst_i = 1'b0;
      #1;
      `CHK(res, res_t'('0))
      repeat (2) @(negedge clk_i);
      nrst_i = 1'b1;
      @(posedge clk_i);
      #1;
      mode_fields(MODE_SHORT, 8'h10);
   endtask

   task automatic finish_test;
      if (mismatches == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // main sequence and hang guard
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         mismatches++;
         finish_test();
      end
   end

   initial begin
      repeat (16) @(negedge clk_i);
      nrst_i = 1'b1;
      @(posedge clk_i);
      #1;
      t_short();
      t_sfr();
      t_direct();
      t_reg();
      t_pointer();
      t_reset();
      finish_test();
   end
endmodule
